// >>> jcs_jtag_config_sequencer.sv
// Purpose: Host that configures, starts or shuts down a device over boundary scan
// Assumes: Equal IR length for all chain devices; device 0 sits nearest TDO
// Notes:   Bitstream arrives as 32-bit words, MSB first; last word may be partial
`timescale 1ns/1ps
module jcs_jtag_config_sequencer
  import jcs_pkg::*;
#(
  parameter logic [13:0] SHUTDOWN_SMALL = 14'h0000,
  parameter logic [13:0] SHUTDOWN_LARGE = 14'h0000
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        op_shutdown,
  input  wire logic        dev_large,
  input  wire logic [2:0]  chain_last,
  input  wire logic [2:0]  target_index,
  input  wire logic [31:0] bs_len,
  input  wire logic        bs_valid,
  input  wire logic [31:0] bs_data,
  output logic             bs_ready,
  output logic             busy,
  output logic             done,
  output logic             tck,
  output logic             tms,
  output logic             tdi,
  output logic             program_reset_pin_n,
  output logic             mode_select_bit2,
  output logic             mode_select_bit1,
  output logic             mode_select_bit0
);

  jcs_state_t  state_r,    state_nxt;
  logic [4:0]  cnt_r,      cnt_nxt;
  logic        phase_r,    phase_nxt;
  logic        op_sd_r,    op_sd_nxt;
  logic        large_r,    large_nxt;
  logic [2:0]  last_dev_r, last_dev_nxt;
  logic [2:0]  target_r,   target_nxt;
  logic [31:0] len_r,      len_nxt;
  logic [2:0]  dev_r,      dev_nxt;
  logic [3:0]  irbit_r,    irbit_nxt;
  logic [31:0] dr_left_r,  dr_left_nxt;
  logic [2:0]  pad_r,      pad_nxt;
  logic [31:0] word_r,     word_nxt;
  logic [5:0]  wcnt_r,     wcnt_nxt;
  logic        bs_ready_r, bs_ready_nxt;
  logic        busy_r,     busy_nxt;
  logic        done_r,     done_nxt;
  logic        prog_r;
  logic [2:0]  mode_r;

  logic        bit_valid;
  logic        bit_tms;
  logic        bit_tdi;
  logic        bit_ready;
  logic        fire;
  logic        fixed;
  logic        fix_tms;
  jcs_state_t  fix_next;
  logic [4:0]  fix_cnt;
  logic [13:0] ir_code;
  logic [3:0]  ir_last;
  logic        ir_end;
  logic        dr_end;
  logic        take;

  jcs_tck_engine jcs_tck_engine_inst (
    .clk       (clk),
    .rst       (rst),
    .bit_valid (bit_valid),
    .bit_tms   (bit_tms),
    .bit_tdi   (bit_tdi),
    .bit_ready (bit_ready),
    .tck       (tck),
    .tms       (tms),
    .tdi       (tdi)
  );

  always_comb begin
    // Instruction for the device now being shifted
    if (dev_r == target_r) begin
      if (!phase_r) begin
        ir_code = large_r ? CFG_IN_LARGE : CFG_IN_SMALL;
      end else if (op_sd_r) begin
        ir_code = large_r ? SHUTDOWN_LARGE : SHUTDOWN_SMALL;
      end else begin
        ir_code = large_r ? STARTUP_LARGE : STARTUP_SMALL;
      end
    end else if (phase_r && !op_sd_r) begin
      ir_code = large_r ? STARTUP_LARGE : STARTUP_SMALL;
    end else begin
      ir_code = BYPASS_CODE;
    end
    ir_last = large_r ? IR_LAST_LARGE : IR_LAST_SMALL;
    ir_end  = (dev_r == last_dev_r) && (irbit_r == ir_last);
    dr_end  = ((dr_left_r == 32'h0000_0001) && (pad_r == 3'h0)) ||
              ((dr_left_r == 32'h0000_0000) && (pad_r == 3'h1));
    take    = bs_valid && bs_ready_r;
  end

  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    phase_nxt    = phase_r;
    op_sd_nxt    = op_sd_r;
    large_nxt    = large_r;
    last_dev_nxt = last_dev_r;
    target_nxt   = target_r;
    len_nxt      = len_r;
    dev_nxt      = dev_r;
    irbit_nxt    = irbit_r;
    dr_left_nxt  = dr_left_r;
    pad_nxt      = pad_r;
    word_nxt     = word_r;
    wcnt_nxt     = wcnt_r;
    busy_nxt     = busy_r;
    done_nxt     = 1'b0;
    bit_valid    = 1'b0;
    bit_tms      = 1'b0;
    bit_tdi      = 1'b0;
    fixed        = 1'b0;
    fix_tms      = 1'b0;
    fix_next     = S_IDLE;
    fix_cnt      = 5'h00;

    case (state_r)
      S_IDLE: begin
        if (start) begin
          op_sd_nxt    = op_shutdown;
          large_nxt    = dev_large;
          last_dev_nxt = chain_last;
          target_nxt   = target_index;
          len_nxt      = bs_len;
          phase_nxt    = 1'b0;
          wcnt_nxt     = 6'h00;
          busy_nxt     = 1'b1;
          cnt_nxt      = TLR_CLOCKS - 5'h01;
          state_nxt    = S_TLR;
        end
      end
      S_TLR: begin
        fixed    = 1'b1;
        fix_tms  = 1'b1;
        fix_next = S_RTI;
        fix_cnt  = RTI_CLOCKS - 5'h01;
      end
      S_RTI: begin
        fixed    = 1'b1;
        fix_next = S_SELIR;
        fix_cnt  = SELECT_CLOCKS - 5'h01;
      end
      S_SELIR: begin
        fixed    = 1'b1;
        fix_tms  = 1'b1;
        fix_next = S_ENTIR;
        fix_cnt  = ENTER_CLOCKS - 5'h01;
      end
      S_ENTIR: begin
        fixed    = 1'b1;
        fix_next = S_IR;
      end
      S_SELDR: begin
        fixed    = 1'b1;
        fix_tms  = 1'b1;
        fix_next = S_ENTDR;
        fix_cnt  = ENTER_CLOCKS - 5'h01;
      end
      S_ENTDR: begin
        fixed    = 1'b1;
        fix_next = S_DR;
      end
      S_UPD: begin
        fixed    = 1'b1;
        fix_tms  = 1'b1;
        fix_next = op_sd_r ? S_RTI : S_TLR;
        fix_cnt  = op_sd_r ? RTI_CLOCKS - 5'h01 : TLR_CLOCKS - 5'h01;
      end
      S_UPIR: begin
        fixed    = 1'b1;
        fix_tms  = 1'b1;
        fix_next = S_RUN;
        fix_cnt  = RUN_CLOCKS - 5'h01;
      end
      S_RUN: begin
        fixed    = 1'b1;
        fix_next = S_FIN;
        fix_cnt  = FINISH_CLOCKS - 5'h01;
      end
      S_FIN: begin
        fixed    = 1'b1;
        fix_tms  = 1'b1;
        fix_next = S_IDLE;
      end
      S_IR: begin
        bit_valid = 1'b1;
        bit_tdi   = ir_code[irbit_r];
        bit_tms   = ir_end;
        if (bit_ready) begin
          if (ir_end) begin
            state_nxt = phase_r ? S_UPIR : S_SELDR;
            cnt_nxt   = phase_r ? UPDATE_CLOCKS - 5'h01 : SELECT_CLOCKS - 5'h01;
          end else if (irbit_r == ir_last) begin
            irbit_nxt = 4'h0;
            dev_nxt   = dev_r + 3'h1;
          end else begin
            irbit_nxt = irbit_r + 4'h1;
          end
        end
      end
      S_DR: begin
        bit_valid = (dr_left_r != 32'h0000_0000) ? (wcnt_r != 6'h00) : 1'b1;
        bit_tdi   = (dr_left_r != 32'h0000_0000) && word_r[31];
        bit_tms   = dr_end;
        if (bit_valid && bit_ready) begin
          if (dr_left_r != 32'h0000_0000) begin
            dr_left_nxt = dr_left_r - 32'h0000_0001;
            word_nxt    = {word_r[30:0], 1'b0};
            wcnt_nxt    = wcnt_r - 6'h01;
          end else begin
            pad_nxt = pad_r - 3'h1;
          end
          if (dr_end) begin
            state_nxt = S_UPD;
            cnt_nxt   = UPDATE_CLOCKS - 5'h01;
          end
        end
      end
      default: begin
        state_nxt = S_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase

    if (fixed) begin
      bit_valid = 1'b1;
      bit_tms   = fix_tms;
      if (bit_ready) begin
        if (cnt_r == 5'h00) begin
          state_nxt = fix_next;
          cnt_nxt   = fix_cnt;
          dev_nxt   = 3'h0;
          irbit_nxt = 4'h0;
          if (fix_next == S_DR) begin
            dr_left_nxt = len_r;
            pad_nxt     = last_dev_r - target_r;
          end
          if (state_r == S_UPD) begin
            phase_nxt = 1'b1;
          end
          if (state_r == S_FIN) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
          end
        end else begin
          cnt_nxt = cnt_r - 5'h01;
        end
      end
    end

    if (take) begin
      word_nxt = bs_data;
      wcnt_nxt = WORD_BITS;
    end
    bs_ready_nxt = (state_r == S_DR) && (dr_left_r != 32'h0000_0000) &&
                   (wcnt_r == 6'h00) && !take;
  end

  // S_IR/S_DR leave cnt_r unused; S_SELDR entry count set on IR exit
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r    <= S_IDLE;
      cnt_r      <= 5'h00;
      phase_r    <= 1'b0;
      op_sd_r    <= 1'b0;
      large_r    <= 1'b0;
      last_dev_r <= 3'h0;
      target_r   <= 3'h0;
      len_r      <= 32'h0000_0000;
      dev_r      <= 3'h0;
      irbit_r    <= 4'h0;
      dr_left_r  <= 32'h0000_0000;
      pad_r      <= 3'h0;
      word_r     <= 32'h0000_0000;
      wcnt_r     <= 6'h00;
      bs_ready_r <= 1'b0;
      busy_r     <= 1'b0;
      done_r     <= 1'b0;
      prog_r     <= PROG_INACTIVE;
      mode_r     <= MODE_SELECT;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      phase_r    <= phase_nxt;
      op_sd_r    <= op_sd_nxt;
      large_r    <= large_nxt;
      last_dev_r <= last_dev_nxt;
      target_r   <= target_nxt;
      len_r      <= len_nxt;
      dev_r      <= dev_nxt;
      irbit_r    <= irbit_nxt;
      dr_left_r  <= dr_left_nxt;
      pad_r      <= pad_nxt;
      word_r     <= word_nxt;
      wcnt_r     <= wcnt_nxt;
      bs_ready_r <= bs_ready_nxt;
      busy_r     <= busy_nxt;
      done_r     <= done_nxt;
      prog_r     <= PROG_INACTIVE;
      mode_r     <= MODE_SELECT;
    end
  end

  assign fire                = bit_valid && bit_ready;
  assign bs_ready            = bs_ready_r;
  assign busy                = busy_r;
  assign done                = done_r;
  assign program_reset_pin_n = prog_r;
  assign mode_select_bit2    = mode_r[2];
  assign mode_select_bit1    = mode_r[1];
  assign mode_select_bit0    = mode_r[0];

  // Clocks given in the current state, for checking only
  logic [4:0] seg_cnt_r;
  always_ff @(posedge clk) begin
    if (rst || state_nxt != state_r) begin
      seg_cnt_r <= 5'h00;
    end else if (fire) begin
      seg_cnt_r <= seg_cnt_r + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_tlr_five;
    (state_r == S_TLR && state_nxt != S_TLR) |-> bit_tms && seg_cnt_r == 5'h04;
  endproperty
  a_tlr_five: assert property (p_tlr_five)
    else $error("Reset walk not five TMS-high clocks");

  property p_to_shift_ir;
    (state_r == S_ENTIR && state_nxt == S_IR) |-> !bit_tms && seg_cnt_r == 5'h01;
  endproperty
  a_to_shift_ir: assert property (p_to_shift_ir)
    else $error("Shift-IR entry walk wrong");

  property p_ir_exit;
    (state_r == S_IR && fire && bit_tms) |-> bit_tdi && ir_end ##1 state_r != S_IR;
  endproperty
  a_ir_exit: assert property (p_ir_exit)
    else $error("Instruction exit bit wrong");

  property p_to_shift_dr;
    (state_r == S_ENTDR && state_nxt == S_DR) |-> !bit_tms && seg_cnt_r == 5'h01;
  endproperty
  a_to_shift_dr: assert property (p_to_shift_dr)
    else $error("Shift-DR entry walk wrong");

  property p_dr_last;
    (state_r == S_DR && fire) |-> (bit_tms == dr_end) ##1 (tms == (state_r != S_DR));
  endproperty
  a_dr_last: assert property (p_dr_last)
    else $error("Data exit not on last bit");

  property p_run_twelve;
    (state_r == S_RUN && state_nxt != S_RUN) |-> !bit_tms && seg_cnt_r == 5'h0B
      ##1 state_r == S_FIN;
  endproperty
  a_run_twelve: assert property (p_run_twelve)
    else $error("Run-Test/Idle did not get twelve clocks");

  property p_finish_three;
    (state_r == S_FIN && state_nxt != S_FIN) |-> bit_tms && seg_cnt_r == 5'h02
      ##1 done_r && !busy_r;
  endproperty
  a_finish_three: assert property (p_finish_three)
    else $error("Final walk to reset wrong");

  property p_prog_inactive;
    busy_r |-> program_reset_pin_n == PROG_INACTIVE;
  endproperty
  a_prog_inactive: assert property (p_prog_inactive)
    else $error("Program pin active during scan work");

  property p_mode_pins;
    ##1 {mode_select_bit2, mode_select_bit1, mode_select_bit0} == MODE_SELECT;
  endproperty
  a_mode_pins: assert property (p_mode_pins)
    else $error("Mode-select pins not at scan setting");

endmodule // jcs_jtag_config_sequencer

// >>> jcs_pkg.sv
// Purpose: Shared constants and types for the boundary-scan configuration host
// Assumes: 40 MHz system clock, host generates TCK by dividing it
// Notes:   Instruction codes are held at the large-device width of 14 bits
package jcs_pkg;

  // Clocking of the generated TCK
  localparam int CLK_PERIOD_NS = 25;
  localparam int TCK_PERIOD_NS = 200;
  localparam int TCK_HALF_CYC  = ((TCK_PERIOD_NS / 2) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TCK_HALF_CNT = 4'(TCK_HALF_CYC - 1);

  // TCK counts of the fixed TAP walking segments
  localparam logic [4:0] TLR_CLOCKS    = 5'h05;
  localparam logic [4:0] RTI_CLOCKS    = 5'h01;
  localparam logic [4:0] SELECT_CLOCKS = 5'h02;
  localparam logic [4:0] ENTER_CLOCKS  = 5'h02;
  localparam logic [4:0] UPDATE_CLOCKS = 5'h01;
  localparam logic [4:0] RUN_CLOCKS    = 5'h0C;
  localparam logic [4:0] FINISH_CLOCKS = 5'h03;

  // Instruction register lengths, minus one
  localparam logic [3:0] IR_LAST_SMALL = 4'h9;
  localparam logic [3:0] IR_LAST_LARGE = 4'hD;

  // Instruction codes, LSB is shifted first
  localparam logic [13:0] CFG_IN_SMALL  = 14'h03C5;
  localparam logic [13:0] CFG_IN_LARGE  = 14'h3FC5;
  localparam logic [13:0] STARTUP_SMALL = 14'h03CC;
  localparam logic [13:0] STARTUP_LARGE = 14'h3FCC;
  localparam logic [13:0] BYPASS_CODE   = 14'h3FFF;

  // Static pin levels
  localparam logic       PROG_INACTIVE = 1'h1;
  localparam logic [2:0] MODE_SELECT   = 3'h5;

  // Bitstream word feed
  localparam logic [5:0] WORD_BITS = 6'h20;

  typedef enum logic [12:0] {
    S_IDLE  = 13'b0_0000_0000_0001,
    S_TLR   = 13'b0_0000_0000_0010,
    S_RTI   = 13'b0_0000_0000_0100,
    S_SELIR = 13'b0_0000_0000_1000,
    S_ENTIR = 13'b0_0000_0001_0000,
    S_IR    = 13'b0_0000_0010_0000,
    S_SELDR = 13'b0_0000_0100_0000,
    S_ENTDR = 13'b0_0000_1000_0000,
    S_DR    = 13'b0_0001_0000_0000,
    S_UPD   = 13'b0_0010_0000_0000,
    S_UPIR  = 13'b0_0100_0000_0000,
    S_RUN   = 13'b0_1000_0000_0000,
    S_FIN   = 13'b1_0000_0000_0000
  } jcs_state_t;

  typedef enum logic [2:0] {
    E_IDLE  = 3'b001,
    E_SETUP = 3'b010,
    E_HIGH  = 3'b100
  } jcs_eng_t;

endpackage : jcs_pkg

// >>> jcs_tck_engine.sv
// Purpose: Produces one TCK period per accepted bit with TMS and TDI
// Assumes: Request inputs come from logic on clk
// Notes:   TMS and TDI change only while TCK is low, when a bit is accepted
`timescale 1ns/1ps
module jcs_tck_engine
  import jcs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic bit_valid,
  input  wire logic bit_tms,
  input  wire logic bit_tdi,
  output logic      bit_ready,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);

  jcs_eng_t   st_r,  st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic       tck_r, tck_nxt;
  logic       tms_r, tms_nxt;
  logic       tdi_r, tdi_nxt;

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    tck_nxt   = tck_r;
    tms_nxt   = tms_r;
    tdi_nxt   = tdi_r;
    bit_ready = (st_r == E_IDLE);
    case (st_r)
      E_IDLE: begin
        if (bit_valid) begin
          tms_nxt = bit_tms;
          tdi_nxt = bit_tdi;
          cnt_nxt = TCK_HALF_CNT;
          st_nxt  = E_SETUP;
        end
      end
      E_SETUP: begin
        if (cnt_r == 4'h0) begin
          tck_nxt = 1'b1;
          cnt_nxt = TCK_HALF_CNT;
          st_nxt  = E_HIGH;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      E_HIGH: begin
        if (cnt_r == 4'h0) begin
          tck_nxt = 1'b0;
          st_nxt  = E_IDLE;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: begin
        tck_nxt = 1'b0;
        st_nxt  = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r  <= E_IDLE;
      cnt_r <= 4'h0;
      tck_r <= 1'b0;
      tms_r <= 1'b1;
      tdi_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      tck_r <= tck_nxt;
      tms_r <= tms_nxt;
      tdi_r <= tdi_nxt;
    end
  end

  assign tck = tck_r;
  assign tms = tms_r;
  assign tdi = tdi_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_tck_high_width;
    $rose(tck_r) |-> tck_r [*4] ##1 !tck_r;
  endproperty
  a_tck_high_width: assert property (p_tck_high_width)
    else $error("TCK high phase has wrong length");

  property p_pins_hold_high;
    tck_r |-> $stable(tms_r) && $stable(tdi_r);
  endproperty
  a_pins_hold_high: assert property (p_pins_hold_high)
    else $error("TMS or TDI moved while TCK high");

  property p_setup_before_rise;
    $rose(tck_r) |-> $past(tms_r, 4) == tms_r && $past(tdi_r, 4) == tdi_r;
  endproperty
  a_setup_before_rise: assert property (p_setup_before_rise)
    else $error("TMS or TDI not set up before rising TCK");

endmodule // jcs_tck_engine

// >>> jcs_dev_model.sv
// Purpose: Behavioural boundary-scan device, 10-bit instruction register
// Assumes: Single device, TCK from the host
// Notes:   Counts startup clocks in Run-Test/Idle
`timescale 1ns/1ps
module jcs_dev_model #(
  parameter logic [9:0]  START_CODE = 10'h3CC,
  parameter logic [31:0] HOLD_CMD   = 32'h0000_0007
)(
  input  wire logic       tck,
  input  wire logic       tms,
  input  wire logic       tdi,
  output wire logic       tdo,
  output logic      [3:0] st,
  output logic      [9:0] ir,
  output logic            hold,
  output wire logic       started
);
  logic [9:0]  irs;
  logic [63:0] dr;
  logic        bp;
  logic [3:0]  nx;
  int          cnt;
  initial begin
    st = 4'h0;
    ir = 10'h3FF;
    hold = 1'b0;
    cnt = 0;
  end
  always_comb begin
    case (st)
      4'h0: nx = tms ? 4'h0 : 4'h1;
      4'h1: nx = tms ? 4'h2 : 4'h1;
      4'h2: nx = tms ? 4'h9 : 4'h3;
      4'h3: nx = tms ? 4'h5 : 4'h4;
      4'h4: nx = tms ? 4'h5 : 4'h4;
      4'h5: nx = tms ? 4'h8 : 4'h6;
      4'h6: nx = tms ? 4'h7 : 4'h6;
      4'h7: nx = tms ? 4'h8 : 4'h4;
      4'h9: nx = tms ? 4'h0 : 4'hA;
      4'hA: nx = tms ? 4'hC : 4'hB;
      4'hB: nx = tms ? 4'hC : 4'hB;
      4'hC: nx = tms ? 4'hF : 4'hD;
      4'hD: nx = tms ? 4'hE : 4'hD;
      4'hE: nx = tms ? 4'hF : 4'hB;
      default: nx = tms ? 4'h2 : 4'h1;
    endcase
  end
  always @(posedge tck) begin
    st <= nx;
    if (st == 4'hB) irs <= {tdi, irs[9:1]};
    if (st == 4'hF) ir <= irs;
    if (st == 4'h4) dr <= {dr[62:0], tdi};
    if (st == 4'h8 && dr[31:0] == HOLD_CMD) hold <= 1'b1;
    if (st == 4'h3) bp <= 1'b0;
    else if (st == 4'h4) bp <= tdi;
    if (st == 4'h1 && ir == START_CODE) cnt <= cnt + 1;
  end
  assign started = (cnt >= 12);
  assign tdo = (st == 4'h4) ? (&ir ? bp : dr[63]) : ((st == 4'hB) ? irs[0] : 1'bz);
endmodule // jcs_dev_model

// >>> jtag_config_sequencer_tb.sv
// Purpose: Self-checking bench for the configuration host
// Assumes: Pin sequence compared per TCK rising edge
// Notes:   Shutdown codes below are arbitrary
`timescale 1ns/1ps
module jtag_config_sequencer_tb;
  import jcs_pkg::*;
  localparam logic [13:0] SHD_S = 14'h03CD;
  localparam logic [13:0] SHD_L = 14'h3FCD;
  logic        clk, rst, start, op_shutdown, dev_large, bs_valid;
  logic [2:0]  chain_last, target_index;
  logic [31:0] bs_len, bs_data;
  wire  logic  bs_ready, busy, done, tck, tms, tdi, prog, m2, m1, m0, tdo, dm_started, dm_hold;
  wire  logic [3:0] dm_st;
  wire  logic [9:0] dm_ir;
  int          n_mismatch, n_compared, cyc;
  logic [2:0]  expq[$];
  logic [1:0]  gotq[$];
  logic [31:0] words[$];
  jcs_jtag_config_sequencer #(.SHUTDOWN_SMALL(SHD_S), .SHUTDOWN_LARGE(SHD_L))
    jcs_jtag_config_sequencer_inst (.clk(clk), .rst(rst), .start(start),
    .op_shutdown(op_shutdown), .dev_large(dev_large), .chain_last(chain_last),
    .target_index(target_index), .bs_len(bs_len), .bs_valid(bs_valid), .bs_data(bs_data),
    .bs_ready(bs_ready), .busy(busy), .done(done), .tck(tck), .tms(tms), .tdi(tdi),
    .program_reset_pin_n(prog), .mode_select_bit2(m2), .mode_select_bit1(m1),
    .mode_select_bit0(m0));
  jcs_dev_model jcs_dev_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .st(dm_st),
    .ir(dm_ir), .hold(dm_hold), .started(dm_started));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge tck) if (!rst) gotq.push_back({tms, tdi});
  always @(tms or tdi) if (!rst && tck === 1'b1) begin
    n_mismatch++;
    $display("[ERR] %0t tck %h exp %h", $time, tck, 1'b0);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic m, input logic d, input logic k, input int n);
    repeat (n) expq.push_back({k, m, d});
  endtask
  task automatic ir_load(input logic [13:0] ct, input logic [13:0] co, input int cl,
                         input int tg, input int l);
    for (int v = 0; v <= cl; v++)
      for (int i = 0; i < l; i++) put(v == cl && i == l - 1, (v == tg) ? ct[i] : co[i], 1, 1);
  endtask
  task automatic feed(input int stall);
    foreach (words[w]) begin
      repeat (stall + 1) @(posedge clk);
      bs_valid <= 1'b1;
      bs_data  <= words[w];
      @(posedge clk);
      while (bs_ready !== 1'b1) @(posedge clk);
      bs_valid <= 1'b0;
      bs_data  <= ~words[w];
    end
  endtask
  task automatic run_op(input logic sh, input logic big, input int cl, input int tg,
                        input int len, input int stall, input logic poke);
    int l;
    int n;
    int t;
    l = big ? 14 : 10;
    t = len + cl - tg;
    expq.delete();
    gotq.delete();
    put(1, 0, 0, 5);
    put(0, 0, 0, 1);
    put(1, 0, 0, 2);
    put(0, 0, 0, 2);
    ir_load(big ? 14'h3FC5 : 14'h03C5, 14'h3FFF, cl, tg, l);
    put(1, 0, 0, 2);
    put(0, 0, 0, 2);
    for (int i = 0; i < t; i++) put(i == t - 1, (i < len) ? words[i / 32][31 - i % 32] : 1'b0, 1, 1);
    put(1, 0, 0, sh ? 1 : 6);
    put(0, 0, 0, 1);
    put(1, 0, 0, 2);
    put(0, 0, 0, 2);
    if (sh) ir_load(big ? SHD_L : SHD_S, 14'h3FFF, cl, tg, l);
    else ir_load(big ? 14'h3FCC : 14'h03CC, big ? 14'h3FCC : 14'h03CC, cl, tg, l);
    put(1, 0, 0, 1);
    put(0, 0, 0, 12);
    put(1, 0, 0, 3);
    op_shutdown  <= sh;
    dev_large    <= big;
    chain_last   <= cl[2:0];
    target_index <= tg[2:0];
    bs_len       <= len;
    start        <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    fork
      feed(stall);
      begin
        @(posedge clk);
        check(busy, 1'b1);
        start <= poke;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40000) begin
          @(posedge clk);
          n++;
        end
        check(busy, 1'b0);
        // Done comes with the last bit accepted; let its TCK finish
        repeat (10) @(posedge clk);
      end
    join
    check(gotq.size(), expq.size());
    for (int i = 0; i < expq.size() && i < gotq.size() && n_mismatch < 8; i++)
      check({gotq[i][1], gotq[i][0] & expq[i][2]}, {expq[i][1], expq[i][0] & expq[i][2]});
  endtask
  task automatic s_single();
    words = '{32'hAA99_5566, 32'h1234_5678};
    run_op(0, 0, 0, 0, 40, 1, 0);
    check(dm_st, 4'h0);
    check(dm_started, 1'b1);
    check(dm_ir, 10'h3CC);
    check({prog, m2, m1, m0}, 4'hD);
    check(dm_hold, 1'b0);
  endtask
  task automatic s_chain();
    words = '{32'h0123_4567, 32'h8000_0000};
    run_op(0, 1, 2, 1, 33, 400, 1);
    check(dm_st, 4'h0);
  endtask
  task automatic s_shutdown();
    words = '{32'h5A5A_0F0F, 32'h0000_0007};
    run_op(1, 0, 0, 0, 64, 1, 0);
    check(dm_ir, {SHD_S[9:0]});
    check(prog, 1'b1);
    check(dm_hold, 1'b1);
  endtask
  initial begin
    rst = 1'b1;
    start = 1'b0;
    op_shutdown = 1'b0;
    dev_large = 1'b0;
    chain_last = 3'h0;
    target_index = 3'h0;
    bs_len = 32'h0000_0001;
    bs_valid = 1'b0;
    bs_data = 32'h0000_0000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    s_single();
    s_chain();
    s_shutdown();
    final_report();
  end
endmodule // jtag_config_sequencer_tb
